// File: sac_pkg.sv
// Shared constants and types of the sampling converter control block.
// Assumes a single 250 MHz clock and nothing else from its surroundings.
`default_nettype none

package sac_pkg;

   // Result and serial word layout.
   localparam int unsigned RES_W = 12;
   localparam int unsigned WORD_W = 13;
   localparam int unsigned FLAG_POS = 12;
   localparam logic [3:0] MSB_IDX = 4'hb;
   localparam logic [3:0] WORD_BITS = 4'hd;
   localparam logic [11:0] RESULT_RESET = 12'h000;

   // Buffering between the converter and the serial shifter.
   localparam int unsigned FIFO_DEPTH = 4;

   // Trigger pulse counts, taken while the host clock is held low.
   localparam logic [2:0] NAP_PULSES = 3'h2;
   localparam logic [2:0] SLEEP_PULSES = 3'h4;

   // Wake-up clock pulse: figure in ns, count in cycles, rounded up.
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned WAKE_PULSE_NS = 50;
   localparam int unsigned WAKE_CYC_INT =
      (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] WAKE_CYC = 4'(WAKE_CYC_INT);

   // Conversion sequencer, Gray coded along idle, convert, push.
   typedef enum logic [1:0] {
      SAC_IDLE = 2'h0,
      SAC_CONVERT = 2'h1,
      SAC_PUSH = 2'h3
   } sac_conversion_trigger_state_type;

   // Power state, Gray coded along active, nap, sleep.
   typedef enum logic [1:0] {
      SAC_ACTIVE = 2'h0,
      SAC_NAP = 2'h1,
      SAC_SLEEP = 2'h3
   } sac_power_state_type;

endpackage

`default_nettype wire

// File: sac_stream_if.sv
// Valid and ready stream carrying one serial word between modules.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface sac_stream_if #(parameter int unsigned W = 13);
   logic valid;
   logic ready;
   logic [W-1:0] data;

   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

`default_nettype wire

// File: sac_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module sac_fifo #(
   parameter int unsigned W = 13,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic srst_i,
   // Write and read sides.
   sac_stream_if.sink in_bus,
   sac_stream_if.source out_bus
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } sac_fifo_state_type;

   sac_fifo_state_type st;
   sac_fifo_state_type next_st;
   logic push;
   logic pop;

   // Full and empty come straight from the stored count.
   assign in_bus.ready = (st.count != (AW+1)'(DEPTH));
   assign out_bus.valid = (st.count != '0);
   assign out_bus.data = st.mem[st.rd];
   assign push = in_bus.valid & in_bus.ready;
   assign pop = out_bus.valid & out_bus.ready;

   // Pointer and count update; a push into a full buffer cannot happen.
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = in_bus.data;
         next_st.wr = st.wr + 1'b1;
      end
      if (pop) begin
         next_st.rd = st.rd + 1'b1;
      end
      case ({push, pop})
         2'b10: next_st.count = st.count + 1'b1;
         2'b01: next_st.count = st.count - 1'b1;
         default: next_st.count = st.count;
      endcase
   end

   // State register.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule

`default_nettype wire

// File: sac_adc_ctrl.sv
// Control logic of a 12-bit successive-approximation converter with a
// three-wire serial port. Assumes the host clock and trigger pins are
// synchronous to clock_i and the comparator settles within one cycle.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - A rising edge on the conversion trigger starts a new conversion.
// - The approximation result register is cleared before any bit decision.
// - Trigger edges during a running conversion are ignored; no restart.
// - Bits are decided MSB to LSB, one per host clock step, twelve.
// - At the end the finished 12-bit word becomes the serial output data.
// - The result leaves one bit at a time on the serial data pin.
// - Serial output changes only in step with the host clock.
// - Timing abuse may drop requests; a nap request recovers operation.
// - Clock low plus two trigger pulses puts the device into nap.
// - Clock low plus four trigger pulses puts the device into sleep.
// - A host clock pulse of at least 50ns wakes from nap or sleep.
// - Serial word carries a reference settled flag, low when reference low.
// - Unipolar results are straight binary, one code per millivolt.
// - Bipolar results are in two's complement.
module sac_adc_ctrl
   import sac_pkg::*;
(
   // Clock and reset.
   input wire logic clock_i,
   input wire logic srst_i,
   // Host pins.
   input wire logic host_clk_i,
   input wire logic conversion_trigger_i,
   output logic serial_data_o,
   output logic serial_data_oe_o,
   // Analog front end.
   input wire logic comparator_i,
   input wire logic ref_low_i,
   input wire logic bipolar_i,
   output logic [11:0] dac_trial_o,
   output logic sample_o,
   // Status.
   output logic busy_o,
   output logic nap_o,
   output logic sleep_o
);

   typedef struct packed {
      sac_conversion_trigger_state_type cstate;
      sac_power_state_type pstate;
      logic clk_q;
      logic trig_q;
      logic [2:0] pulse_cnt;
      logic [3:0] wake_cnt;
      logic [11:0] approximation_result_reg;
      logic [11:0] trial;
      logic [3:0] bit_idx;
      logic [12:0] word;
      logic [12:0] shift;
      logic [3:0] shift_cnt;
      logic dout;
      logic oe;
   } sac_state_type;

   sac_state_type st;
   sac_state_type next_st;
   logic clk_rise;
   logic trig_rise;
   logic nap_req;
   logic sleep_req;
   logic last_bit;
   logic [11:0] decided;

   sac_stream_if #(.W(WORD_W)) push_bus ();
   sac_stream_if #(.W(WORD_W)) pop_bus ();

   // One-hot weight of the bit under test.
   function automatic logic [11:0] bit_weight(input logic [3:0] idx);
      bit_weight = 12'h001 << idx;
   endfunction

   // Output coding: bipolar flips the MSB of the offset-binary result.
   function automatic logic [11:0] code_of(input logic [11:0] res,
                                           input logic bip);
      code_of = {res[11] ^ bip, res[10:0]};
   endfunction

   // Edge detection on pins that are already synchronous to clock_i.
   assign clk_rise = host_clk_i & ~st.clk_q;
   assign trig_rise = conversion_trigger_i & ~st.trig_q;
   assign nap_req = trig_rise & ~host_clk_i &
                    (st.pulse_cnt == NAP_PULSES - 3'h1);
   assign sleep_req = trig_rise & ~host_clk_i &
                      (st.pulse_cnt == SLEEP_PULSES - 3'h1);
   assign last_bit = (st.cstate == SAC_CONVERT) & clk_rise &
                     (st.bit_idx == 4'h0);
   assign decided = st.approximation_result_reg |
                    (comparator_i ? bit_weight(st.bit_idx) : 12'h000);

   // Words wait in the buffer; a full buffer holds the sequencer in push.
   assign push_bus.valid = (st.cstate == SAC_PUSH);
   assign push_bus.data = st.word;
   assign pop_bus.ready = (st.shift_cnt == 4'h0) & ~st.oe;

   sac_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .in_bus(push_bus),
      .out_bus(pop_bus)
   );

   // Next-state logic for sequencer, power control and shifter.
   always_comb begin
      next_st = st;
      next_st.clk_q = host_clk_i;
      next_st.trig_q = conversion_trigger_i;

      // Trigger pulses count only while the host clock stays low.
      if (host_clk_i) begin
         next_st.pulse_cnt = 3'h0;
      end else if (trig_rise && st.pulse_cnt != SLEEP_PULSES) begin
         next_st.pulse_cnt = st.pulse_cnt + 3'h1;
      end

      // Power state; a wake pulse must stay high for the full count.
      case (st.pstate)
         SAC_ACTIVE: begin
            next_st.wake_cnt = 4'h0;
            if (nap_req) begin
               next_st.pstate = SAC_NAP;
            end
         end
         SAC_NAP, SAC_SLEEP: begin
            if (sleep_req) begin
               next_st.pstate = SAC_SLEEP;
            end else if (host_clk_i) begin
               next_st.wake_cnt = st.wake_cnt + 4'h1;
               if (st.wake_cnt == WAKE_CYC - 4'h1) begin
                  next_st.pstate = SAC_ACTIVE;
                  next_st.wake_cnt = 4'h0;
               end
            end else begin
               next_st.wake_cnt = 4'h0;
            end
         end
         default: begin
            next_st.pstate = SAC_ACTIVE;
         end
      endcase

      // Conversion sequencer, one decision per host clock rising edge.
      case (st.cstate)
         SAC_IDLE: begin
            if (trig_rise && st.pstate == SAC_ACTIVE && !nap_req) begin
               next_st.approximation_result_reg = RESULT_RESET;
               next_st.trial = bit_weight(MSB_IDX);
               next_st.bit_idx = MSB_IDX;
               next_st.cstate = SAC_CONVERT;
            end
         end
         SAC_CONVERT: begin
            // Trigger edges are not looked at here at all.
            if (clk_rise) begin
               next_st.approximation_result_reg = decided;
               if (st.bit_idx == 4'h0) begin
                  next_st.word = {~ref_low_i,
                                  code_of(decided, bipolar_i)};
                  next_st.cstate = SAC_PUSH;
               end else begin
                  next_st.bit_idx = st.bit_idx - 4'h1;
                  next_st.trial = decided | bit_weight(st.bit_idx - 4'h1);
               end
            end
         end
         SAC_PUSH: begin
            if (push_bus.ready) begin
               next_st.cstate = SAC_IDLE;
            end
         end
         default: begin
            next_st.cstate = SAC_IDLE;
         end
      endcase

      // A nap request abandons any conversion and its pending word.
      if (nap_req && st.pstate == SAC_ACTIVE) begin
         next_st.cstate = SAC_IDLE;
      end

      // Serial shifter moves only on host clock rising edges.
      if (clk_rise) begin
         if (st.shift_cnt != 4'h0) begin
            next_st.dout = st.shift[12];
            next_st.shift = {st.shift[11:0], 1'b0};
            next_st.shift_cnt = st.shift_cnt - 4'h1;
            next_st.oe = 1'b1;
         end else begin
            next_st.oe = 1'b0;
         end
      end
      // Loading waits for the release edge, so words never run together.
      if (pop_bus.ready && pop_bus.valid) begin
         next_st.shift = pop_bus.data;
         next_st.shift_cnt = WORD_BITS;
      end
   end

   // State register.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register.
   assign serial_data_o = st.dout;
   assign serial_data_oe_o = st.oe;
   assign dac_trial_o = st.trial;
   assign sample_o = (st.cstate != SAC_CONVERT) & (st.pstate == SAC_ACTIVE);
   assign busy_o = (st.cstate != SAC_IDLE);
   assign nap_o = (st.pstate == SAC_NAP);
   assign sleep_o = (st.pstate == SAC_SLEEP);

   // Checks on the sequencer, power control and shifter.
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);

   a_start_converts: assert property (
      (st.cstate == SAC_IDLE && trig_rise && st.pstate == SAC_ACTIVE &&
       !nap_req) |=> (st.cstate == SAC_CONVERT && st.bit_idx == MSB_IDX))
      else $error("Trigger edge did not start a conversion.");

   a_result_cleared: assert property (
      ($rose(busy_o)) |-> (st.approximation_result_reg == 12'h000 &&
                           dac_trial_o == 12'h800))
      else $error("Result register not cleared at conversion start.");

   a_no_restart: assert property (
      (st.cstate == SAC_CONVERT && trig_rise && !clk_rise && !nap_req)
      |=> $stable(st.bit_idx) && $stable(st.approximation_result_reg))
      else $error("Trigger edge disturbed a running conversion.");

   a_msb_to_lsb: assert property (
      (st.cstate == SAC_CONVERT && clk_rise && st.bit_idx != 4'h0 &&
       !nap_req) |=> (st.bit_idx == $past(st.bit_idx) - 4'h1))
      else $error("Bit decision order broken.");

   a_word_ready: assert property (
      (last_bit && !nap_req) |=> (st.cstate == SAC_PUSH) ##0 push_bus.valid)
      else $error("Finished word not offered for output.");

   a_shift_bit: assert property (
      (clk_rise && st.shift_cnt != 4'h0)
      |=> (serial_data_oe_o && serial_data_o == $past(st.shift[12])))
      else $error("Serial bit not driven on host clock edge.");

   a_out_in_step: assert property (
      ($changed(serial_data_o) || $changed(serial_data_oe_o))
      |-> $past(clk_rise))
      else $error("Serial output changed without a host clock edge.");

   a_nap_abort: assert property (
      (nap_req && st.pstate == SAC_ACTIVE)
      |=> (nap_o && !busy_o))
      else $error("Nap request did not stop the converter.");

   a_sleep_entry: assert property (
      (sleep_req) |=> sleep_o [*2])
      else $error("Fourth pulse did not enter sleep.");

   a_wake_count: assert property (
      (st.pstate != SAC_ACTIVE && host_clk_i && !sleep_req &&
       st.wake_cnt == WAKE_CYC - 4'h1) |=> (!nap_o && !sleep_o))
      else $error("Wake pulse did not return to active.");

   a_flag_low: assert property (
      (last_bit && ref_low_i) |=> !st.word[FLAG_POS])
      else $error("Settled flag high with reference low.");

   a_unipolar_code: assert property (
      (last_bit && !bipolar_i)
      |=> (st.word[11:0] == st.approximation_result_reg))
      else $error("Unipolar code not straight binary.");

   a_bipolar_code: assert property (
      (last_bit && bipolar_i)
      |=> (st.word[11] != st.approximation_result_reg[11]))
      else $error("Bipolar code sign bit wrong.");

   a_release: assert property (
      (clk_rise && st.shift_cnt == 4'h0 && st.oe) |=> !serial_data_oe_o)
      else $error("Serial pin not released after the word.");

   c_conversion: cover property (last_bit);
   c_nap: cover property (nap_req && st.pstate == SAC_ACTIVE);
   c_sleep: cover property (sleep_req);
   c_word_out: cover property (clk_rise && st.shift_cnt == 4'h1);

endmodule

`default_nettype wire

// File: sac_host.sv
// Host model: drives the serial clock, the trigger and the comparator and
// collects the serial words. Assumes pins are sampled on the rising clock.
`timescale 1ns/100ps
`default_nettype none

module sac_host
   import sac_pkg::*;
(
   // System clock.
   input wire logic clock_i,
   // Device side.
   input wire logic [11:0] dac_trial_i,
   input wire logic serial_data_i,
   input wire logic serial_data_oe_i,
   output logic host_clk_o,
   output logic trig_o,
   output logic comp_o
);
   logic [11:0] vin;
   logic [12:0] shreg;
   int nbits;
   int bad_len;
   logic [12:0] words[$];

   // Pins idle low so the first trigger is a clean rising edge.
   initial begin
      host_clk_o = 1'b0;
      trig_o = 1'b0;
      vin = 12'h000;
      shreg = 13'h0000;
      nbits = 0;
      bad_len = 0;
   end

   // Ideal comparator: keep the trial bit while it does not exceed vin.
   always @(negedge clock_i) begin
      comp_o <= (dac_trial_i <= vin);
   end

   // One clock pulse; data is taken late in the high phase, after the
   // device has had hi rising edges of clock_i to update its pin.
   task automatic clk_pulse(input int hi);
      @(negedge clock_i) host_clk_o = 1'b1;
      repeat (hi) @(negedge clock_i);
      if (serial_data_oe_i === 1'b1) begin
         shreg = {shreg[11:0], serial_data_i};
         nbits++;
      end else if (nbits != 0) begin
         words.push_back(shreg);
         if (nbits != int'(WORD_BITS)) bad_len++;
         nbits = 0;
      end
      host_clk_o = 1'b0;
      repeat (3) @(negedge clock_i);
   endtask

   // Trigger pulse after an idle gap; it drops well inside 120 ns.
   task automatic trig_pulse(input int gap);
      repeat (gap) @(negedge clock_i);
      @(negedge clock_i) trig_o = 1'b1;
      @(negedge clock_i) trig_o = 1'b0;
      @(negedge clock_i);
   endtask
endmodule

`default_nettype wire

// File: tb.sv
// Self-checking bench of the converter control block.
// Assumes the host model drives the host pins and the comparator.
`timescale 1ns/100ps
`default_nettype none

module tb;
   typedef struct packed {
      logic [11:0] v;
      logic rl;
      logic bp;
      logic [12:0] exp;
   } sac_row_type;

   logic clock_i;
   logic srst;
   logic ref_low;
   logic bipolar;
   logic host_clk;
   logic trig;
   logic comp;
   logic sdata;
   logic soe;
   logic [11:0] trial;
   logic busy;
   logic nap;
   logic sleep;
   logic sample;
   int errors = 0;
   int n_tests = 0;
   sac_row_type rows[6] = '{
      '{12'h000, 1'b0, 1'b0, 13'h1000}, '{12'hfff, 1'b0, 1'b0, 13'h1fff},
      '{12'h5a3, 1'b1, 1'b0, 13'h05a3}, '{12'h800, 1'b0, 1'b1, 13'h1000},
      '{12'h7ff, 1'b1, 1'b1, 13'h0fff}, '{12'h001, 1'b0, 1'b1, 13'h1801}};

   sac_adc_ctrl dut (.clock_i(clock_i), .srst_i(srst),
      .host_clk_i(host_clk), .conversion_trigger_i(trig),
      .serial_data_o(sdata), .serial_data_oe_o(soe), .comparator_i(comp),
      .ref_low_i(ref_low), .bipolar_i(bipolar), .dac_trial_o(trial),
      .sample_o(sample), .busy_o(busy), .nap_o(nap), .sleep_o(sleep));

   sac_host host (.clock_i(clock_i), .dac_trial_i(trial),
      .serial_data_i(sdata), .serial_data_oe_i(soe), .host_clk_o(host_clk),
      .trig_o(trig), .comp_o(comp));

   // 250 MHz system clock.
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   task automatic check(input logic [12:0] got, input logic [12:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Start, twelve decisions, optional stray trigger mid-way.
   task automatic convert(input logic [11:0] v, input bit retrig);
      host.vin = v;
      host.trig_pulse(60);
      check(13'(busy), 13'h1);
      check(13'(sample), 13'h0);
      check(13'(trial), 13'h0800);
      for (int i = 0; i < 12; i++) begin
         host.clk_pulse(3);
         if (i == 0) check(13'(trial), v[11] ? 13'h0c00 : 13'h0400);
         if (retrig && i == 5) begin
            host.trig_pulse(0);
            check(13'(busy), 13'h1);
            check(13'(trial), 13'((v & 12'hfc0) | 12'h020));
         end
      end
      repeat (4) @(negedge clock_i);
      check(13'(busy), 13'h0);
   endtask

   // Clocks the port until a word arrives, then compares it.
   task automatic expect_word(input logic [12:0] exp);
      int k;
      k = 0;
      while (host.words.size() == 0 && k < 40) begin
         host.clk_pulse(3);
         k++;
      end
      check(13'(host.words.size() != 0), 13'h1);
      if (host.words.size() != 0) check(host.words.pop_front(), exp);
   endtask

   // Watchdog, far beyond the expected few thousand cycles.
   initial begin
      repeat (20000) @(posedge clock_i);
      errors++;
      results();
   end

   initial begin
      srst = 1'b1;
      ref_low = 1'b0;
      bipolar = 1'b0;
      repeat (2) @(negedge clock_i);
      srst = 1'b0;
      @(negedge clock_i);
      check({busy, nap, sleep, soe, trial[8:0]}, 13'h0000);
      check(13'(sample), 13'h1);
      // Table of conversions with every coding and flag setting.
      foreach (rows[i]) begin
         ref_low = rows[i].rl;
         bipolar = rows[i].bp;
         convert(rows[i].v, i == 2);
         expect_word(rows[i].exp);
      end
      // Back to back: the second conversion clocks out twelve bits of the first word.
      ref_low = 1'b1;
      bipolar = 1'b1;
      convert(12'h3c5, 1'b0);
      convert(12'hc3a, 1'b0);
      expect_word(13'h0bc5);
      expect_word(13'h043a);
      check(13'(host.bad_len), 13'h0);
      // Nap by two pulses with the clock low; triggers then ignored.
      host.trig_pulse(60);
      host.trig_pulse(0);
      check(13'({nap, busy}), 13'h2);
      check(13'(sample), 13'h0);
      host.trig_pulse(0);
      check(13'(busy), 13'h0);
      host.clk_pulse(12);
      check(13'(nap), 13'h1);
      host.clk_pulse(13);
      check(13'(nap), 13'h0);
      ref_low = 1'b0;
      bipolar = 1'b0;
      convert(12'h9e1, 1'b0);
      expect_word(13'h19e1);
      // Sleep by four pulses, woken by one long clock pulse.
      for (int i = 0; i < 4; i++) host.trig_pulse(i == 0 ? 60 : 0);
      check(13'(sleep), 13'h1);
      host.clk_pulse(13);
      check(13'({sleep, nap}), 13'h0);
      // Second reset in mid-conversion.
      host.trig_pulse(60);
      repeat (4) host.clk_pulse(3);
      @(negedge clock_i) srst = 1'b1;
      repeat (2) @(negedge clock_i);
      srst = 1'b0;
      @(negedge clock_i);
      check({busy, soe, trial[10:0]}, 13'h0000);
      convert(12'h2b4, 1'b0);
      expect_word(13'h12b4);
      results();
   end
endmodule

`default_nettype wire
